/* File: inc/cpc_defs.vh */
// constants for the configuration port pin control block
`ifndef CPC_DEFS_VH
`define CPC_DEFS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CPC_CLK_HZ          50000000
`define CPC_WAIT_MIN_US     30
`define CPC_WAIT_MAX_US     300
// least wait in whole cycles; the clock-to-MHz divide truncates
`define CPC_WAIT_CYC        ((`CPC_WAIT_MIN_US * (`CPC_CLK_HZ / 1000000)))
`define CPC_CLEAR_CYC       64

// ----------------------------------------
// widths
// ----------------------------------------
`define CPC_ADDR_W          18
`define CPC_DATA_W          8
`define CPC_FIFO_DEPTH      8

// ----------------------------------------
// modes
// ----------------------------------------
`define CPC_MODE_PERIPH     2'h0
`define CPC_MODE_MASTER_PAR 2'h1
`define CPC_MODE_CHAIN      2'h2

// ----------------------------------------
// phases
// ----------------------------------------
`define CPC_ST_CLEAR        3'h0
`define CPC_ST_WAIT         3'h1
`define CPC_ST_MWAIT        3'h2
`define CPC_ST_LOAD         3'h3
`define CPC_ST_ERROR        3'h4
`define CPC_ST_USER         3'h5

`endif

/* File: hw/cpc_fifo.v */
// byte fifo between the configuration port and the loader core
`timescale 1ns/10ps

module cpc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            do_wr;
  wire            do_rd;

  // honest flags straight from the occupancy count
  assign in_ready_out  = (count_ff != DEPTH[AW:0]);
  assign out_valid_out = (count_ff != {(AW+1){1'b0}});
  assign out_data_out  = mem_ff[rd_ptr_ff];
  assign do_wr         = in_valid_in & in_ready_out;
  assign do_rd         = out_valid_out & out_ready_in;

  // storage write, no reset needed on the data itself
  always @(posedge clk_in)
  begin
    if (do_wr)
    begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  // pointers wrap naturally when depth is a power of two
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd)
      begin
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_wr & ~do_rd)
      begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end
      else if (do_rd & ~do_wr)
      begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // cpc_fifo

/* File: hw/cpc_config_port.v */
// configuration port pin control: init handshake, peripheral port, rom addressing
`timescale 1ns/10ps
`include "cpc_defs.vh"

module cpc_config_port #(
  parameter WAIT_CYC    = `CPC_WAIT_CYC,
  parameter CLEAR_CYC   = `CPC_CLEAR_CYC,
  parameter ADDR_W      = `CPC_ADDR_W,
  parameter FIFO_DEPTH  = `CPC_FIFO_DEPTH
) (
  input  wire              CLK_IN,
  input  wire              SYS_RST_IN,
  input  wire [1:0]        MODE_IN,
  input  wire              INIT_N_IN,
  output reg               INIT_N_OUT,
  output reg               INIT_N_OE_N_OUT,
  input  wire              SELECT_LOW_N_IN,
  input  wire              SELECT_HIGH_IN,
  input  wire              WRITE_STROBE_N_IN,
  input  wire              READ_STROBE_N_IN,
  input  wire [7:0]        CONFIG_DATA_BUS_IN,
  output reg  [7:0]        CONFIG_DATA_BUS_OUT,
  output reg               CONFIG_DATA_BUS_OE_N_OUT,
  output reg  [ADDR_W-1:0] CONFIG_ROM_ADDR_OUT,
  output reg               CONFIG_ROM_ADDR_EN_OUT,
  output reg               READY_OUT,
  output reg               CHAIN_ENABLE_OUT,
  output reg               CONFIG_ACTIVE_OUT,
  output reg  [7:0]        BYTE_DATA_OUT,
  output reg               BYTE_VALID_OUT,
  input  wire              BYTE_READY_IN,
  input  wire              DATA_ERROR_IN,
  input  wire              CONFIG_DONE_IN
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg  [4:0]        sync1_ff;
  reg  [4:0]        sync2_ff;
  reg  [7:0]        dsync1_ff;
  reg  [7:0]        dsync2_ff;
  wire              init_pin;
  wire              sel_low_n;
  wire              sel_high;
  wire              wr_n;
  wire              rd_n;

  // first stage is read only by the second stage
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      sync1_ff  <= 5'h1f;
      sync2_ff  <= 5'h1f;
      dsync1_ff <= 8'h00;
      dsync2_ff <= 8'h00;
    end
    else
    begin
      sync1_ff  <= {INIT_N_IN, SELECT_LOW_N_IN, SELECT_HIGH_IN,
                    WRITE_STROBE_N_IN, READ_STROBE_N_IN};
      sync2_ff  <= sync1_ff;
      dsync1_ff <= CONFIG_DATA_BUS_IN;
      dsync2_ff <= dsync1_ff;
    end
  end

  assign init_pin  = sync2_ff[4];
  assign sel_low_n = sync2_ff[3];
  assign sel_high  = sync2_ff[2];
  assign wr_n      = sync2_ff[1];
  assign rd_n      = sync2_ff[0];

  // ----------------------------------------
  // phase sequencer
  // ----------------------------------------
  reg  [2:0]        state_ff;
  reg  [2:0]        nxt_state;
  reg  [15:0]       cnt_ff;
  reg  [15:0]       nxt_cnt;
  reg  [1:0]        mode_ff;
  wire              master_mode;

  assign master_mode = (mode_ff == `CPC_MODE_MASTER_PAR);

  // next phase; mode straps are caught on the way out of clearing
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 16'h0001;
    case (state_ff)
      `CPC_ST_CLEAR:
      begin
        if (cnt_ff >= CLEAR_CYC[15:0] - 16'h0001)
        begin
          nxt_state = `CPC_ST_WAIT;
          nxt_cnt   = 16'h0000;
        end
      end
      `CPC_ST_WAIT:
      begin
        nxt_cnt = 16'h0000;
        if (init_pin)
        begin
          nxt_state = master_mode ? `CPC_ST_MWAIT : `CPC_ST_LOAD;
        end
      end
      `CPC_ST_MWAIT:
      begin
        if (!init_pin)
        begin
          nxt_state = `CPC_ST_WAIT;
          nxt_cnt   = 16'h0000;
        end
        else if (cnt_ff >= WAIT_CYC[15:0] - 16'h0001)
        begin
          nxt_state = `CPC_ST_LOAD;
          nxt_cnt   = 16'h0000;
        end
      end
      `CPC_ST_LOAD:
      begin
        nxt_cnt = 16'h0000;
        if (DATA_ERROR_IN)
        begin
          nxt_state = `CPC_ST_ERROR;
        end
        else if (CONFIG_DONE_IN)
        begin
          nxt_state = `CPC_ST_USER;
        end
      end
      `CPC_ST_ERROR:
      begin
        nxt_cnt = 16'h0000;                          // held until reset
      end
      `CPC_ST_USER:
      begin
        nxt_cnt = 16'h0000;
      end
      default:
      begin
        nxt_state = `CPC_ST_CLEAR;
        nxt_cnt   = 16'h0000;
      end
    endcase
  end

  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_ff <= `CPC_ST_CLEAR;
      cnt_ff   <= 16'h0000;
      mode_ff  <= `CPC_MODE_PERIPH;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (state_ff == `CPC_ST_CLEAR)
      begin
        mode_ff <= MODE_IN;
      end
    end
  end

  // ----------------------------------------
  // peripheral port
  // ----------------------------------------
  wire              loading;
  wire              stay_load;
  wire              selected;
  wire              periph;
  wire              wr_act;
  wire              rd_act;
  reg               wr_d_ff;
  wire              wr_pulse;
  wire              fifo_in_ready;
  wire              fifo_out_valid;
  wire [7:0]        fifo_out_data;
  wire              fifo_take;
  reg               fifo_in_valid;
  reg  [7:0]        fifo_in_data;
  reg  [ADDR_W-1:0] addr_ff;
  reg               fetch_ff;

  assign loading  = (state_ff == `CPC_ST_LOAD);
  // bus, rom address and ready pins are let go on the edge that leaves loading, not one cycle late; chain enable follows one cycle later
  assign stay_load = loading & (nxt_state == `CPC_ST_LOAD);
  assign periph   = (mode_ff != `CPC_MODE_MASTER_PAR);
  assign selected = ~sel_low_n & sel_high;
  // write wins when both strobes are low
  assign wr_act   = selected & ~wr_n;
  assign rd_act   = selected & ~rd_n & wr_n;
  // byte is taken at the rising edge of the strobe, when data has settled
  assign wr_pulse = wr_d_ff & ~wr_act;

  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      wr_d_ff <= 1'b0;
    end
    else
    begin
      wr_d_ff <= wr_act & loading & periph;
    end
  end

  // data source: host writes in peripheral modes, rom fetches in master mode
  always @*
  begin
    fifo_in_data  = dsync2_ff;
    fifo_in_valid = loading & (periph ? wr_pulse : fetch_ff);
  end

  // a write while busy is dropped; the host is expected to poll first
  cpc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk_in        (CLK_IN),
    .rst_in        (SYS_RST_IN),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_take),
    .out_data_out  (fifo_out_data)
  );

  assign fifo_take = BYTE_READY_IN & fifo_out_valid & ~BYTE_VALID_OUT;

  // rom fetch: one address per byte, two cycles apart to let data settle
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      addr_ff  <= {ADDR_W{1'b0}};
      fetch_ff <= 1'b0;
    end
    else if (loading & master_mode)
    begin
      fetch_ff <= ~fetch_ff & fifo_in_ready;
      if (fetch_ff)
      begin
        addr_ff <= addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
    else
    begin
      fetch_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      INIT_N_OUT               <= 1'b0;
      INIT_N_OE_N_OUT          <= 1'b0;
      CONFIG_DATA_BUS_OUT      <= 8'hff;
      CONFIG_DATA_BUS_OE_N_OUT <= 1'b1;
      CONFIG_ROM_ADDR_OUT      <= {ADDR_W{1'b0}};
      CONFIG_ROM_ADDR_EN_OUT   <= 1'b0;
      READY_OUT                <= 1'b0;
      CHAIN_ENABLE_OUT         <= 1'b0;
      CONFIG_ACTIVE_OUT        <= 1'b1;
      BYTE_DATA_OUT            <= 8'h00;
      BYTE_VALID_OUT           <= 1'b0;
    end
    else
    begin
      // open drain: only ever drive low, release otherwise
      INIT_N_OUT      <= 1'b0;
      INIT_N_OE_N_OUT <= ~((nxt_state == `CPC_ST_CLEAR) |
                           (nxt_state == `CPC_ST_ERROR));
      // released to user logic in USER state
      CONFIG_DATA_BUS_OUT      <= {fifo_in_ready, 7'h7f};
      CONFIG_DATA_BUS_OE_N_OUT <= ~(rd_act & stay_load & periph);
      CONFIG_ROM_ADDR_OUT      <= addr_ff;
      CONFIG_ROM_ADDR_EN_OUT   <= stay_load & master_mode;
      READY_OUT                <= stay_load & fifo_in_ready;
      CHAIN_ENABLE_OUT         <= (mode_ff == `CPC_MODE_CHAIN) & loading & sel_high;
      CONFIG_ACTIVE_OUT        <= (nxt_state != `CPC_ST_USER);
      if (fifo_take)
      begin
        BYTE_DATA_OUT  <= fifo_out_data;
        BYTE_VALID_OUT <= 1'b1;
      end
      else if (BYTE_READY_IN)
      begin
        BYTE_VALID_OUT <= 1'b0;
      end
    end
  end

endmodule // cpc_config_port

/* File: tb/cpc_config_port_sva.sv */
// assertion checker for the configuration port pins
`timescale 1ns/10ps

module cpc_config_port_sva #(
  parameter ADDR_W = 18
) (
  input wire logic              CLK_IN,
  input wire logic              SYS_RST_IN,
  input wire logic [1:0]        MODE_IN,
  input wire logic              INIT_N_IN,
  input wire logic              INIT_N_OE_N_OUT,
  input wire logic              SELECT_LOW_N_IN,
  input wire logic              SELECT_HIGH_IN,
  input wire logic              WRITE_STROBE_N_IN,
  input wire logic              READ_STROBE_N_IN,
  input wire logic [7:0]        CONFIG_DATA_BUS_OUT,
  input wire logic              CONFIG_DATA_BUS_OE_N_OUT,
  input wire logic [ADDR_W-1:0] CONFIG_ROM_ADDR_OUT,
  input wire logic              CONFIG_ROM_ADDR_EN_OUT,
  input wire logic              READY_OUT,
  input wire logic              CONFIG_ACTIVE_OUT,
  input wire logic              DATA_ERROR_IN
);
  // ----------------------------------------
  // pin behaviour
  // ----------------------------------------
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_init_clear_low: assert property (
    $fell(SYS_RST_IN) |-> !INIT_N_OE_N_OUT [*3])
    else $error("init not held low while clearing");
  a_wait_no_load: assert property (
    !INIT_N_IN && !READY_OUT && !CONFIG_ROM_ADDR_EN_OUT
    |=> !READY_OUT && !CONFIG_ROM_ADDR_EN_OUT)
    else $error("load began while init held");
  a_master_extra_wait: assert property (
    $rose(INIT_N_IN) && MODE_IN == 2'h1 |-> !CONFIG_ROM_ADDR_EN_OUT [*8])
    else $error("rom fetch began too soon");
  a_error_init_low: assert property (
    DATA_ERROR_IN && (READY_OUT || CONFIG_ROM_ADDR_EN_OUT)
    |-> ##[1:3] !INIT_N_OE_N_OUT)
    else $error("data error not flagged on init");
  a_user_release: assert property (
    !CONFIG_ACTIVE_OUT |-> INIT_N_OE_N_OUT && CONFIG_DATA_BUS_OE_N_OUT
    && !CONFIG_ROM_ADDR_EN_OUT)
    else $error("pins kept after done");
  a_deselect_quiet: assert property (
    SELECT_LOW_N_IN [*5] |-> CONFIG_DATA_BUS_OE_N_OUT)
    else $error("bus driven while deselected");
  a_status_read: assert property (
    (!SELECT_LOW_N_IN && SELECT_HIGH_IN && !READ_STROBE_N_IN
    && WRITE_STROBE_N_IN && READY_OUT) [*4]
    |-> !CONFIG_DATA_BUS_OE_N_OUT && CONFIG_DATA_BUS_OUT == 8'hff)
    else $error("status read wrong");
  a_write_wins: assert property (
    (!WRITE_STROBE_N_IN && !READ_STROBE_N_IN) [*5] |-> CONFIG_DATA_BUS_OE_N_OUT)
    else $error("read driven during write");
  a_rom_addr_step: assert property (
    CONFIG_ROM_ADDR_EN_OUT && $past(CONFIG_ROM_ADDR_EN_OUT, 2)
    |-> CONFIG_ROM_ADDR_OUT - $past(CONFIG_ROM_ADDR_OUT, 2) == 18'h1)
    else $error("rom address step");
endmodule // cpc_config_port_sva

bind cpc_config_port cpc_config_port_sva #(.ADDR_W(ADDR_W)) cpc_config_port_sva_i (.CLK_IN,
  .SYS_RST_IN, .MODE_IN, .INIT_N_IN, .INIT_N_OE_N_OUT, .SELECT_LOW_N_IN, .SELECT_HIGH_IN,
  .WRITE_STROBE_N_IN, .READ_STROBE_N_IN, .CONFIG_DATA_BUS_OUT, .CONFIG_DATA_BUS_OE_N_OUT,
  .CONFIG_ROM_ADDR_OUT, .CONFIG_ROM_ADDR_EN_OUT, .READY_OUT, .CONFIG_ACTIVE_OUT, .DATA_ERROR_IN);

/* File: tb/cpc_host_model.sv */
// host processor and parallel rom model on the configuration pins
`timescale 1ns/10ps

module cpc_host_model (
  input  wire logic        clk_in,
  input  wire logic [7:0]  dev_data_in,
  input  wire logic        dev_oe_n_in,
  input  wire logic        init_oe_n_in,
  input  wire logic [17:0] rom_addr_in,
  input  wire logic        rom_en_in,
  output wire logic        init_n_out,
  output logic             sel_low_n_out,
  output logic             sel_high_out,
  output logic             ws_n_out,
  output logic             rs_n_out,
  output wire logic [7:0]  data_out
);
  logic       hold = 1'b1;
  logic       drv = 1'b0;
  logic [7:0] dat = 8'h00;
  logic [7:0] pat = 8'h00;

  // undriven bus shows a moving pattern so stale data never passes
  always @(posedge clk_in) pat <= ~pat;
  assign data_out = rom_en_in ? rom_addr_in[7:0] ^ 8'h5a
                  : drv ? dat : !dev_oe_n_in ? dev_data_in : pat;
  // open drain with pull-up; host may hold it low
  assign init_n_out = init_oe_n_in & ~hold;
  initial {sel_low_n_out, sel_high_out, ws_n_out, rs_n_out} = 4'hb;

  // write strobe pulse; also_rd breaks the one-strobe habit on purpose
  task wr(input logic [7:0] d, input logic sh, input logic also_rd);
    begin
      @(negedge clk_in);
      dat = d;
      drv = 1'b1;
      sel_low_n_out = 1'b0;
      sel_high_out = sh;
      ws_n_out = 1'b0;
      rs_n_out = ~also_rd;
      repeat (6) @(negedge clk_in);
      ws_n_out = 1'b1;
      rs_n_out = 1'b1;
      repeat (5) @(negedge clk_in);
      drv = 1'b0;
      sel_low_n_out = 1'b1;
      sel_high_out = 1'b0;
    end
  endtask

  // status read: the value is taken while the strobe is still low
  task rd(output logic [7:0] v);
    begin
      @(negedge clk_in);
      sel_low_n_out = 1'b0;
      sel_high_out = 1'b1;
      rs_n_out = 1'b0;
      repeat (6) @(negedge clk_in);
      v = data_out;
      rs_n_out = 1'b1;
      @(negedge clk_in);
      sel_low_n_out = 1'b1;
      sel_high_out = 1'b0;
    end
  endtask
endmodule // cpc_host_model

/* File: tb/cpc_config_port_tb.sv */
// self-checking bench for the configuration port pin control
`timescale 1ns/10ps

module cpc_config_port_tb;
  logic clk = 0, rst = 1, bready = 0, err = 0, done = 0;
  logic [1:0] mode = 2'h0;
  logic [1:0] rmode = 2'h0;
  logic [7:0] d, v;
  logic [31:0] r;
  int errors = 0, compares = 0, cyc = 0, n, k;
  logic [7:0] got[$], exp[$];
  wire init_pin, init_o, init_oe_n, sl_n, sh, ws_n, rs_n, doe_n, aen, ready, chain, active, bvalid;
  wire [7:0] bus, dout, bdata;
  wire [17:0] addr;

  always #10 clk = ~clk;

  cpc_config_port #(.WAIT_CYC(10), .CLEAR_CYC(4)) cpc_config_port_i (.CLK_IN(clk),
    .SYS_RST_IN(rst), .MODE_IN(mode), .INIT_N_IN(init_pin), .INIT_N_OUT(init_o),
    .INIT_N_OE_N_OUT(init_oe_n), .SELECT_LOW_N_IN(sl_n), .SELECT_HIGH_IN(sh),
    .WRITE_STROBE_N_IN(ws_n), .READ_STROBE_N_IN(rs_n), .CONFIG_DATA_BUS_IN(bus),
    .CONFIG_DATA_BUS_OUT(dout), .CONFIG_DATA_BUS_OE_N_OUT(doe_n), .CONFIG_ROM_ADDR_OUT(addr),
    .CONFIG_ROM_ADDR_EN_OUT(aen), .READY_OUT(ready), .CHAIN_ENABLE_OUT(chain),
    .CONFIG_ACTIVE_OUT(active), .BYTE_DATA_OUT(bdata), .BYTE_VALID_OUT(bvalid),
    .BYTE_READY_IN(bready), .DATA_ERROR_IN(err), .CONFIG_DONE_IN(done));

  cpc_host_model cpc_host_model_i (.clk_in(clk), .dev_data_in(dout), .dev_oe_n_in(doe_n),
    .init_oe_n_in(init_oe_n), .rom_addr_in(addr), .rom_en_in(aen), .init_n_out(init_pin),
    .sel_low_n_out(sl_n), .sel_high_out(sh), .ws_n_out(ws_n), .rs_n_out(rs_n), .data_out(bus));

  // core side: 0 stalls, 1 pulls at random, 2 always pulls
  always @(negedge clk)
  begin
    r = $urandom;
    bready <= (rmode == 2'h2) | ((rmode == 2'h1) & r[0]);
  end
  always @(posedge clk) if (bvalid === 1'b1 && bready === 1'b1) got.push_back(bdata);
  // hang guard well beyond the expected run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      errors++;
      test_done;
    end
  end

  task chk(input string nm, input logic [17:0] seen, input logic [17:0] want);
    begin
      compares++;
      if (seen !== want)
      begin
        errors++;
        $display("Error %s expected %h seen %h", nm, want, seen);
      end
    end
  endtask

  task test_done;
    begin
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // reset in a mode, hold init low past clearing, then let loading begin
  task start(input logic [1:0] m);
    begin
      rst = 1;
      mode = m;
      err = 0;
      done = 0;
      cpc_host_model_i.hold = 1;
      repeat (6) @(negedge clk);
      rst = 0;
      repeat (3) begin @(negedge clk); chk("init_clear", init_oe_n, 0); end
      repeat (20) @(negedge clk);
      chk("wait_held", {ready, aen}, 0);
      chk("init_level", init_o, 0);
      cpc_host_model_i.hold = 0;
      n = 0;
      while (ready !== 1 && aen !== 1 && n < 100) begin @(negedge clk); n++; end
      chk("load_start", (m != 2'h1 || n >= 10) && n < 100, 1);
    end
  endtask

  // let the core take every byte, then compare in order
  task drain;
    begin
      rmode = 1;
      n = 0;
      while (got.size() < exp.size() && n < 400) begin @(negedge clk); n++; end
      repeat (10) @(negedge clk);
      chk("byte_count", got.size(), exp.size());
      foreach (exp[i]) if (i < got.size()) chk("byte", got[i], exp[i]);
      got.delete();
      exp.delete();
    end
  endtask

  initial
  begin
    void'($urandom(32'h6ede6be1));
    start(2'h0);
    cpc_host_model_i.rd(v);
    chk("status", v, 8'hff);
    rmode = 1;
    for (int i = 0; i < 6; i++)
    begin
      n = 0;
      while (ready !== 1 && n < 200) begin @(negedge clk); n++; end
      d = 8'($urandom);
      cpc_host_model_i.wr(d, 1, 0);
      exp.push_back(d);
    end
    drain;
    // core stalls: fill until busy, then one write that must be dropped
    rmode = 0;
    k = 0;
    while (ready === 1 && k < 12)
    begin
      d = 8'($urandom);
      cpc_host_model_i.wr(d, 1, 0);
      exp.push_back(d);
      k++;
    end
    chk("fifo_depth", k >= 8 && k <= 9, 1);
    cpc_host_model_i.wr(8'ha5, 1, 0);
    drain;
    cpc_host_model_i.wr(8'h3c, 0, 0);
    cpc_host_model_i.wr(8'hc3, 1, 1);
    exp.push_back(8'hc3);
    drain;
    err = 1;
    repeat (4) @(negedge clk);
    chk("error_init", init_oe_n, 0);
    start(2'h1);
    rmode = 2;
    repeat (40) @(negedge clk);
    chk("rom_fetch", aen === 1 && addr > 0 && got.size() > 0, 1);
    done = 1;
    repeat (4) @(negedge clk);
    chk("user_mode", {active, init_oe_n, doe_n, aen}, 18'h6);
    got.delete();
    start(2'h2);
    for (int i = 0; i < 2; i++)
    begin
      cpc_host_model_i.sel_high_out = !i;
      repeat (5) @(negedge clk);
      chk("chain_en", chain, !i);
    end
    test_done;
  end
endmodule // cpc_config_port_tb
